// *** ums_pkg.sv ***
// shared constants and types for the dual serial channel pin block
package ums_pkg;
   // clock and reset timing
   localparam int CLK_PERIOD_NS = 20;             // system clock period
   localparam int RST_MIN_NS    = 40;             // least reset pulse width
   localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // serial framing
   localparam int OVS_RATE      = 16;             // oversample ticks per bit
   localparam int IR_PULSE      = 3;              // infrared pulse, ticks of sixteen
   localparam int MID_TICK      = 7;              // sample point within a bit
   localparam int DATA_BITS     = 8;              // bits per character
   // register offsets within one channel
   localparam logic [3:0] OFS_DATA  = 4'h0;       // transmit write, receive read
   localparam logic [3:0] OFS_IEN   = 4'h1;       // interrupt enable register
   localparam logic [3:0] OFS_MCTL  = 4'h2;       // modem control register
   localparam logic [3:0] OFS_EFEAT = 4'h3;       // enhanced feature register
   localparam logic [3:0] OFS_LSTAT = 4'h4;       // line status, read only
   localparam logic [3:0] OFS_MSTAT = 4'h5;       // inverted modem pin levels, read only
   localparam logic [3:0] OFS_ISTAT = 4'h6;       // sticky events, write one to clear
   localparam logic [3:0] OFS_IMASK = 4'h7;       // event mask
   localparam logic [3:0] OFS_DIV   = 4'h8;       // oversample clock divisor
   // field positions
   localparam int MC_DTR   = 0;                   // terminal ready level
   localparam int MC_RTS   = 1;                   // request to send level
   localparam int MC_IRQEN = 3;                   // interrupt output enable
   localparam int MC_IR    = 6;                   // infrared select
   localparam int EF_ARTS  = 6;                   // automatic request to send
   localparam int EF_ACTS  = 7;                   // automatic clear to send
   localparam int IE_RTS   = 6;                   // report request-to-send changes
   localparam int IE_CTS   = 7;                   // report clear-to-send changes
   localparam int EV_RXAV  = 0;                   // character received
   localparam int EV_TXEMP = 1;                   // transmit holding emptied
   localparam int EV_CTS   = 2;                   // clear to send changed
   localparam int EV_RTS   = 3;                   // request to send changed
   localparam int EV_GPIN  = 4;                   // general purpose input changed
   // reset values
   localparam logic [7:0] REG_RST = 8'h00;        // control registers
   localparam logic [7:0] DIV_RST = 8'h01;        // divisor
   localparam logic [3:0] PIN_RST = 4'hF;         // modem pins seen inactive
   // per channel register request
   typedef struct packed {
      logic [3:0] addr;                           // offset inside channel
      logic [7:0] wdata;                          // write data
      logic       wr;                             // write strobe
      logic       rd;                             // read strobe
   } ums_bus_t;
   // serial machine phases
   typedef enum logic [1:0] {PH_IDLE, PH_START, PH_DATA, PH_STOP} ums_phase_t;
endpackage

// *** ums_pins.sv ***
// two serial channels with modem pins, register port and interrupt outputs
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module ums_chan
   import ums_pkg::*;
#(
   parameter int OVS = OVS_RATE
) (
   input  wire logic     clk,
   input  wire logic     rst,
   input  wire ums_bus_t bus,
   output logic [7:0]    rdata,
   input  wire logic     serial_in,
   input  wire logic     cts_n,
   input  wire logic     dsr_n,
   input  wire logic     cd_n,
   input  wire logic     ri_n,
   output logic          serial_out,
   output logic          rts_n,
   output logic          dtr_n,
   output logic          op2_n,
   output logic          irq,
   output logic          irq_oe,
   output logic          rx_ready_n
);
   // register group
   logic [7:0] ien, mctl, efeat, div, istat, imask;
   logic [7:0] next_ien, next_mctl, next_efeat, next_div, next_istat, next_imask;
   logic [7:0] next_rdata;
   logic [3:0] pins, next_pins;                   // last seen modem inputs
   // oversample divider
   logic [7:0] dcnt, next_dcnt;
   logic       tick;
   // transmit group
   ums_phase_t tx_ph, next_tx_ph;
   logic [3:0] tx_t, next_tx_t;                   // tick within bit
   logic [2:0] tx_i, next_tx_i;                   // data bit index
   logic [7:0] tx_sh, next_tx_sh;                 // shift register
   logic [7:0] thr, next_thr;                     // transmit holding
   logic       thr_full, next_thr_full;
   logic       next_serial_out;
   logic       tx_bit;
   // receive group
   ums_phase_t rx_ph, next_rx_ph;
   logic [3:0] rx_t, next_rx_t;
   logic [2:0] rx_i, next_rx_i;
   logic [7:0] rx_sh, next_rx_sh;
   logic [7:0] receive_holding_reg, next_rhr;                     // receive holding
   logic       rx_valid, next_rx_valid;
   logic [3:0] ir_cnt, next_ir_cnt;               // stretches infrared pulses
   logic       rx_line;
   logic       rx_done, tx_empty_ev;

   // a tick every div+1 clocks; div of zero ticks every clock
   assign tick = (dcnt == div);

   // infrared pulse is short, so it is held for one bit before use
   assign rx_line = mctl[MC_IR] ? !(serial_in || ir_cnt != 4'h0) : serial_in;
   // character accepted at stop mid point
   assign rx_done = (rx_ph == PH_STOP) && tick && (rx_t == 4'(MID_TICK)) && rx_line;

   // modem side outputs
   always_comb begin
      dtr_n = !mctl[MC_DTR];
      // automatic flow holds request off while holding full
      if (efeat[EF_ARTS] && mctl[MC_RTS]) begin
         rts_n = rx_valid;
      end else begin
         rts_n = !mctl[MC_RTS];
      end
      op2_n  = !mctl[MC_IRQEN];
      irq_oe = mctl[MC_IRQEN];
      irq    = |(istat & imask);
      rx_ready_n = !rx_valid;
   end

   // register next values and events
   always_comb begin
      logic [7:0] ev;
      ev          = 8'h00;
      next_ien    = ien;
      next_mctl   = mctl;
      next_efeat  = efeat;
      next_div    = div;
      next_imask  = imask;
      next_rdata  = 8'h00;
      // general inputs only raise an event and show in modem status, nothing else
      next_pins   = {ri_n, cd_n, dsr_n, cts_n};
      ev[EV_RXAV]  = rx_done;
      ev[EV_TXEMP] = tx_empty_ev;
      ev[EV_CTS]   = ien[IE_CTS] && (pins[0] != cts_n);
      ev[EV_RTS]   = ien[IE_RTS] && rx_done && efeat[EF_ARTS];
      ev[EV_GPIN]  = (pins[3:1] != {ri_n, cd_n, dsr_n});
      // set beats write-one clear
      next_istat  = istat;
      if (bus.wr && bus.addr == OFS_ISTAT) begin
         next_istat = istat & ~bus.wdata;
      end
      next_istat = next_istat | ev;
      if (bus.wr) begin
         case (bus.addr)
            OFS_IEN:   next_ien   = bus.wdata;
            OFS_MCTL:  next_mctl  = bus.wdata;
            OFS_EFEAT: next_efeat = bus.wdata;
            OFS_IMASK: next_imask = bus.wdata;
            OFS_DIV:   next_div   = bus.wdata;
            default:   next_div   = div;
         endcase
      end
      if (bus.rd) begin
         case (bus.addr)
            OFS_DATA:  next_rdata = receive_holding_reg;
            OFS_IEN:   next_rdata = ien;
            OFS_MCTL:  next_rdata = mctl;
            OFS_EFEAT: next_rdata = efeat;
            OFS_LSTAT: next_rdata = {6'h00, !thr_full && tx_ph == PH_IDLE, rx_valid};
            OFS_MSTAT: next_rdata = {4'h0, ~pins};
            OFS_ISTAT: next_rdata = istat;
            OFS_IMASK: next_rdata = imask;
            OFS_DIV:   next_rdata = div;
            default:   next_rdata = 8'h00;            // unmapped reads zero
         endcase
      end
      next_dcnt = tick ? 8'h00 : dcnt + 8'h01;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ien   <= REG_RST;
         mctl  <= REG_RST;
         efeat <= REG_RST;
         div   <= DIV_RST;
         istat <= REG_RST;
         imask <= REG_RST;
         rdata <= REG_RST;
         pins  <= PIN_RST;
         dcnt  <= REG_RST;
      end else begin
         ien   <= next_ien;
         mctl  <= next_mctl;
         efeat <= next_efeat;
         div   <= next_div;
         istat <= next_istat;
         imask <= next_imask;
         rdata <= next_rdata;
         pins  <= next_pins;
         dcnt  <= next_dcnt;
      end
   end

   // transmit next values
   always_comb begin
      next_tx_ph    = tx_ph;
      next_tx_t     = tx_t;
      next_tx_i     = tx_i;
      next_tx_sh    = tx_sh;
      next_thr      = thr;
      next_thr_full = thr_full;
      tx_empty_ev   = 1'b0;
      // a write to a full holding register is dropped
      if (bus.wr && bus.addr == OFS_DATA && !thr_full) begin
         next_thr      = bus.wdata;
         next_thr_full = 1'b1;
      end
      if (tick) begin
         next_tx_t = tx_t + 4'h1;
      end
      case (tx_ph)
         PH_IDLE: begin
            next_tx_t = 4'h0;
            // automatic clear to send holds new characters
            if (thr_full && tick && !(efeat[EF_ACTS] && cts_n)) begin
               next_tx_sh    = thr;
               next_thr_full = 1'b0;
               tx_empty_ev   = 1'b1;
               next_tx_ph    = PH_START;
            end
         end
         PH_START: if (tick && tx_t == 4'(OVS - 1)) begin
            next_tx_ph = PH_DATA;
            next_tx_i  = 3'h0;
         end
         PH_DATA: if (tick && tx_t == 4'(OVS - 1)) begin
            next_tx_sh = {1'b0, tx_sh[7:1]};
            next_tx_i  = tx_i + 3'h1;
            if (tx_i == 3'(DATA_BITS - 1)) begin
               next_tx_ph = PH_STOP;
            end
         end
         PH_STOP: if (tick && tx_t == 4'(OVS - 1)) begin
            next_tx_ph = PH_IDLE;
         end
         default: next_tx_ph = PH_IDLE;
      endcase
      // line level of the current bit
      case (tx_ph)
         PH_START: tx_bit = 1'b0;
         PH_DATA:  tx_bit = tx_sh[0];
         default:  tx_bit = 1'b1;
      endcase
      // infrared pulse for zero bits, low otherwise
      if (mctl[MC_IR]) begin
         next_serial_out = !tx_bit && (tx_t < 4'(IR_PULSE));
      end else begin
         next_serial_out = tx_bit;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_ph      <= PH_IDLE;
         tx_t       <= 4'h0;
         tx_i       <= 3'h0;
         tx_sh      <= REG_RST;
         thr        <= REG_RST;
         thr_full   <= 1'b0;
         serial_out <= 1'b1;
      end else begin
         tx_ph      <= next_tx_ph;
         tx_t       <= next_tx_t;
         tx_i       <= next_tx_i;
         tx_sh      <= next_tx_sh;
         thr        <= next_thr;
         thr_full   <= next_thr_full;
         serial_out <= next_serial_out;
      end
   end

   // receive next values
   always_comb begin
      next_rx_ph    = rx_ph;
      next_rx_t     = rx_t;
      next_rx_i     = rx_i;
      next_rx_sh    = rx_sh;
      next_rhr      = receive_holding_reg;
      next_rx_valid = rx_valid;
      next_ir_cnt   = ir_cnt;
      // stretch a pulse for one bit time of ticks
      if (mctl[MC_IR] && serial_in) begin
         next_ir_cnt = 4'(OVS - 1);
      end else if (tick && ir_cnt != 4'h0) begin
         next_ir_cnt = ir_cnt - 4'h1;
      end
      // reading data empties the holding register
      if (bus.rd && bus.addr == OFS_DATA) begin
         next_rx_valid = 1'b0;
      end
      if (tick) begin
         next_rx_t = rx_t + 4'h1;
      end
      case (rx_ph)
         PH_IDLE: begin
            next_rx_t = 4'h0;
            if (tick && !rx_line) begin
               next_rx_ph = PH_START;
            end
         end
         // false start falls back to idle
         PH_START: if (tick && rx_t == 4'(MID_TICK - 1)) begin
            next_rx_ph = rx_line ? PH_IDLE : PH_DATA;
            next_rx_t  = 4'(MID_TICK - OVS + 1);
            next_rx_i  = 3'h0;
         end
         PH_DATA: if (tick && rx_t == 4'(MID_TICK)) begin
            next_rx_sh = {rx_line, rx_sh[7:1]};
            next_rx_i  = rx_i + 3'h1;
            next_rx_t  = 4'(MID_TICK - OVS + 1);
            if (rx_i == 3'(DATA_BITS - 1)) begin
               next_rx_ph = PH_STOP;
            end
         end
         PH_STOP: if (tick && rx_t == 4'(MID_TICK)) begin
            next_rx_ph = PH_IDLE;
            // framing errors are dropped; a new character overwrites
            if (rx_done) begin
               next_rhr      = rx_sh;
               next_rx_valid = 1'b1;
            end
         end
         default: next_rx_ph = PH_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_ph    <= PH_IDLE;
         rx_t     <= 4'h0;
         rx_i     <= 3'h0;
         rx_sh    <= REG_RST;
         receive_holding_reg      <= REG_RST;
         rx_valid <= 1'b0;
         ir_cnt   <= 4'h0;
      end else begin
         rx_ph    <= next_rx_ph;
         rx_t     <= next_rx_t;
         rx_i     <= next_rx_i;
         rx_sh    <= next_rx_sh;
         receive_holding_reg      <= next_rhr;
         rx_valid <= next_rx_valid;
         ir_cnt   <= next_ir_cnt;
      end
   end

   property p_rxrdy;
      @(posedge clk) disable iff (rst) rx_done |=> !rx_ready_n;
   endproperty
   a_rxrdy: assert property (p_rxrdy) else $error("receive ready not low after character");
   property p_std_idle;
      @(posedge clk) disable iff (rst)
         (!mctl[MC_IR] && tx_ph == PH_IDLE)[*2] |-> serial_out;
   endproperty
   a_std_idle: assert property (p_std_idle) else $error("standard line not idle high");
   property p_ir_idle;
      @(posedge clk) disable iff (rst)
         (mctl[MC_IR] && tx_ph == PH_IDLE)[*2] |-> !serial_out;
   endproperty
   a_ir_idle: assert property (p_ir_idle) else $error("infrared line not idle low");
   property p_auto_rts;
      @(posedge clk) disable iff (rst)
         efeat[EF_ARTS] && mctl[MC_RTS] && rx_valid |-> rts_n;
   endproperty
   a_auto_rts: assert property (p_auto_rts) else $error("request not withdrawn when full");
   property p_auto_cts;
      @(posedge clk) disable iff (rst)
         efeat[EF_ACTS] && cts_n && tx_ph == PH_IDLE |=> tx_ph == PH_IDLE;
   endproperty
   a_auto_cts: assert property (p_auto_cts) else $error("sent while clear to send off");
   property p_gp_in;
      @(posedge clk) disable iff (rst)
         $changed(dsr_n) && tx_ph == PH_IDLE && !thr_full |=> tx_ph == PH_IDLE;
   endproperty
   a_gp_in: assert property (p_gp_in) else $error("set ready changed transmit");
   property p_irq_on;
      @(posedge clk) disable iff (rst) $rose(mctl[MC_IRQEN]) |-> irq_oe && !op2_n;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("interrupt not driven");
   property p_irq_off;
      @(posedge clk) disable iff (rst) !mctl[MC_IRQEN] |-> !irq_oe && op2_n;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt not floated");
   property p_modem_out;
      @(posedge clk) disable iff (rst)
         !efeat[EF_ARTS] |-> dtr_n == !mctl[MC_DTR] && rts_n == !mctl[MC_RTS];
   endproperty
   a_modem_out: assert property (p_modem_out) else $error("modem output not inverse");
   property p_rst_tx;
      @(posedge clk) disable iff (rst) $past(rst) |-> serial_out && !rx_valid;
   endproperty
   a_rst_tx: assert property (p_rst_tx) else $error("transmit not high after reset");
endmodule

// top: channel select on address bit four, read data merged
module ums_pins
   import ums_pkg::*;
(
   input  wire logic       SYS_CLK,
   input  wire logic       RST,
   input  wire logic [4:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic [7:0]      RDATA,
   input  wire logic       SERIAL_IN_A,
   input  wire logic       SERIAL_IN_B,
   output logic            SERIAL_OUT_A,
   output logic            SERIAL_OUT_B,
   output logic            REQUEST_TO_SEND_N_A,
   output logic            REQUEST_TO_SEND_N_B,
   input  wire logic       CLEAR_TO_SEND_N_A,
   input  wire logic       CLEAR_TO_SEND_N_B,
   output logic            TERMINAL_READY_N_A,
   output logic            TERMINAL_READY_N_B,
   input  wire logic       SET_READY_N_A,
   input  wire logic       SET_READY_N_B,
   input  wire logic       CARRIER_DETECT_N_A,
   input  wire logic       CARRIER_DETECT_N_B,
   input  wire logic       RING_INDICATOR_N_A,
   input  wire logic       RING_INDICATOR_N_B,
   output logic            AUX_OUTPUT_TWO_N_A,
   output logic            AUX_OUTPUT_TWO_N_B,
   output logic            IRQ_OUT_A,
   output logic            IRQ_OUT_B,
   output logic            IRQ_OUT_OE_A,
   output logic            IRQ_OUT_OE_B,
   output logic            RECEIVE_READY_OUT_N_A,
   output logic            RECEIVE_READY_OUT_N_B
);
   ums_bus_t   bus_a, bus_b;                    // per channel requests
   logic [7:0] rd_a, rd_b;                       // zero unless read last cycle

   // strobes steered by the channel bit
   always_comb begin
      bus_a = '{addr: ADDR[3:0], wdata: WDATA, wr: WR && !ADDR[4], rd: RD && !ADDR[4]};
      bus_b = '{addr: ADDR[3:0], wdata: WDATA, wr: WR && ADDR[4], rd: RD && ADDR[4]};
      RDATA = rd_a | rd_b;
   end

   ums_chan u_chan_a (.clk(SYS_CLK), .rst(RST), .bus(bus_a), .rdata(rd_a),
      .serial_in(SERIAL_IN_A), .cts_n(CLEAR_TO_SEND_N_A), .dsr_n(SET_READY_N_A),
      .cd_n(CARRIER_DETECT_N_A), .ri_n(RING_INDICATOR_N_A), .serial_out(SERIAL_OUT_A),
      .rts_n(REQUEST_TO_SEND_N_A), .dtr_n(TERMINAL_READY_N_A), .op2_n(AUX_OUTPUT_TWO_N_A),
      .irq(IRQ_OUT_A), .irq_oe(IRQ_OUT_OE_A), .rx_ready_n(RECEIVE_READY_OUT_N_A));
   ums_chan u_chan_b (.clk(SYS_CLK), .rst(RST), .bus(bus_b), .rdata(rd_b),
      .serial_in(SERIAL_IN_B), .cts_n(CLEAR_TO_SEND_N_B), .dsr_n(SET_READY_N_B),
      .cd_n(CARRIER_DETECT_N_B), .ri_n(RING_INDICATOR_N_B), .serial_out(SERIAL_OUT_B),
      .rts_n(REQUEST_TO_SEND_N_B), .dtr_n(TERMINAL_READY_N_B), .op2_n(AUX_OUTPUT_TWO_N_B),
      .irq(IRQ_OUT_B), .irq_oe(IRQ_OUT_OE_B), .rx_ready_n(RECEIVE_READY_OUT_N_B));
endmodule

// *** ums_remote.sv ***
// remote serial sender model driving one receive line
`timescale 1ns/1ns
module ums_remote #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [7:0] data,
   output logic            line
);
   logic [9:0] frame;   // start, eight data, stop
   initial line = 1'h1;
   // one 8N1 frame per go pulse, lsb first
   always @(posedge clk) begin
      if (go) begin
         frame = {1'h1, data, 1'h0};
         for (int i = 0; i < 10; i++) begin
            line <= frame[i];
            repeat (BIT_CLKS) @(posedge clk);
         end
         line <= 1'h1;
      end
   end
endmodule

// *** tb.sv ***
// self-checking bench for the dual serial pin block
`timescale 1ns/1ns
module tb;
   import ums_pkg::*;
   typedef struct packed {
      logic [4:0] a;
      logic [7:0] d;
      logic [3:0] e;      // dtr_n, rts_n, aux_n, oe
   } ums_row_t;
   logic       clk = 1'h0;
   logic       rst = 1'h1;
   logic [4:0] addr = 5'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'h0;
   logic       rd = 1'h0;
   logic       go = 1'h0;      // partner frame start
   logic [7:0] gdata = 8'h00;  // partner frame byte
   logic [7:0] rdata;
   logic       rx_a;
   logic       rx_b = 1'h1;    // channel b line, driven by bench
   logic       tx_a;
   logic       tx_b;
   logic [1:0] cts_n = 2'h0;   // index 0 is channel a
   logic [1:0] dsr_n = 2'h3;
   logic [1:0] cd_n = 2'h3;
   logic [1:0] ri_n = 2'h3;
   logic [1:0] rts_n, dtr_n, aux_n, irq, oe, rrdy_n;
   int         err_count = 0;
   int         num_checks = 0;
   int         cyc = 0;
   int         n;
   ums_row_t   rows [6] = '{'{5'h02, 8'h01, 4'h6}, '{5'h02, 8'h02, 4'hA},
      '{5'h02, 8'h08, 4'hD}, '{5'h12, 8'h0B, 4'h1}, '{5'h12, 8'h00, 4'hE},
      '{5'h02, 8'h00, 4'hE}};
   // 50 MHz clock
   always #10 clk = ~clk;
   ums_remote u_far (.clk(clk), .go(go), .data(gdata), .line(rx_a));
   ums_pins u_dut (.SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .SERIAL_IN_A(rx_a), .SERIAL_IN_B(rx_b),
      .SERIAL_OUT_A(tx_a), .SERIAL_OUT_B(tx_b), .REQUEST_TO_SEND_N_A(rts_n[0]),
      .REQUEST_TO_SEND_N_B(rts_n[1]), .CLEAR_TO_SEND_N_A(cts_n[0]),
      .CLEAR_TO_SEND_N_B(cts_n[1]), .TERMINAL_READY_N_A(dtr_n[0]),
      .TERMINAL_READY_N_B(dtr_n[1]), .SET_READY_N_A(dsr_n[0]), .SET_READY_N_B(dsr_n[1]),
      .CARRIER_DETECT_N_A(cd_n[0]), .CARRIER_DETECT_N_B(cd_n[1]),
      .RING_INDICATOR_N_A(ri_n[0]), .RING_INDICATOR_N_B(ri_n[1]),
      .AUX_OUTPUT_TWO_N_A(aux_n[0]), .AUX_OUTPUT_TWO_N_B(aux_n[1]),
      .IRQ_OUT_A(irq[0]), .IRQ_OUT_B(irq[1]), .IRQ_OUT_OE_A(oe[0]), .IRQ_OUT_OE_B(oe[1]),
      .RECEIVE_READY_OUT_N_A(rrdy_n[0]), .RECEIVE_READY_OUT_N_B(rrdy_n[1]));
   // verdict, reached from the main sequence or the timeout
   task automatic close_out();
      if (err_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // hang guard, run needs about nine hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         close_out();
      end
   end
   // four-state compare, x matches only x
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // settle just after a rising edge
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // one-cycle write strobe
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      #1;
   endtask
   // one-cycle read strobe, data only in the next cycle
   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string nm);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 chk(rdata, exp, nm);
   endtask
   // bounded wait for a level on a transmit line
   task automatic wait_tx(input logic ch, input logic lvl);
      n = 0;
      while ((ch ? tx_b : tx_a) !== lvl && n < 300) begin
         tick(1);
         n++;
      end
   endtask
   initial begin
      tick(2);
      chk({tx_a, tx_b, rts_n, dtr_n, aux_n, oe, rrdy_n, irq}, 14'h3FCC, "reset pins");
      chk(rdata, 8'h00, "reset rdata");
      tick(2);
      @(posedge clk) rst <= 1'h0;
      rd_chk(5'h08, 8'h01, "div reset");
      rd_chk(5'h0F, 8'h00, "unmapped");
      wr_reg(5'h08, 8'h00);
      wr_reg(5'h18, 8'h00);
      // modem outputs follow control bits, table driven
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         chk({dtr_n[rows[i].a[4]], rts_n[rows[i].a[4]], aux_n[rows[i].a[4]],
            oe[rows[i].a[4]]}, rows[i].e, "modem pins");
         rd_chk(rows[i].a, rows[i].d, "mctl readback");
      end
      // general inputs asserted while a frame goes out
      @(posedge clk) {dsr_n[0], cd_n[0], ri_n[0]} <= 3'h0;
      rd_chk(5'h05, 8'h0F, "modem status");
      wr_reg(5'h00, 8'h55);
      wait_tx(1'h0, 1'h0);
      tick(8);
      chk(tx_a, 1'h0, "start bit");
      for (int i = 0; i < 8; i++) begin
         tick(16);
         chk(tx_a, 8'h55 >> i & 8'h01, "data bit");
      end
      tick(16);
      chk(tx_a, 1'h1, "stop bit");
      tick(24);
      chk(tx_a, 1'h1, "idle high");
      @(posedge clk) {dsr_n[0], cd_n[0], ri_n[0]} <= 3'h7;
      // infrared transmit on channel b
      @(posedge clk) rx_b <= 1'h0;
      wr_reg(5'h12, 8'h40);
      // transmit line is registered, new idle level one clock later
      tick(1);
      chk(tx_b, 1'h0, "ir idle");
      wr_reg(5'h10, 8'h00);
      wait_tx(1'h1, 1'h1);
      n = 0;
      while (tx_b === 1'h1 && n < 20) begin
         tick(1);
         n++;
      end
      chk(16'(n), 16'(IR_PULSE), "ir pulse");
      tick(200);
      chk(tx_b, 1'h0, "ir idle after");
      // receive with auto rts, interrupt mask and clear
      wr_reg(5'h03, 8'h40);
      wr_reg(5'h07, 8'h01);
      // aux pin driven low along with the interrupt enable
      wr_reg(5'h02, 8'h0A);
      chk({rts_n[0], oe[0], irq[0]}, 3'h2, "masked idle");
      @(posedge clk) go <= 1'h1;
      gdata <= 8'hA5;
      @(posedge clk) go <= 1'h0;
      n = 0;
      while (rrdy_n[0] !== 1'h0 && n < 400) begin
         tick(1);
         n++;
      end
      chk({rrdy_n[0], rts_n[0], irq[0]}, 3'h3, "char held");
      rd_chk(5'h04, 8'h03, "line status");
      rd_chk(5'h00, 8'hA5, "rx data");
      chk({rrdy_n[0], rts_n[0], irq[0]}, 3'h5, "char read");
      wr_reg(5'h06, 8'h01);
      chk(irq[0], 1'h0, "irq cleared");
      wr_reg(5'h07, 8'h03);
      chk(irq[0], 1'h1, "unmasked sticky");
      wr_reg(5'h06, 8'h02);
      chk(irq[0], 1'h0, "second clear");
      // auto cts holds the start of a new char, cts changes reported
      wr_reg(5'h01, 8'h80);
      wr_reg(5'h03, 8'h80);
      @(posedge clk) cts_n[0] <= 1'h1;
      wr_reg(5'h00, 8'h0F);
      tick(60);
      chk(tx_a, 1'h1, "cts held");
      @(posedge clk) cts_n[0] <= 1'h0;
      wait_tx(1'h0, 1'h0);
      chk(tx_a, 1'h0, "cts released");
      rd_chk(5'h06, 8'h16, "event status");
      tick(200);
      close_out();
   end
endmodule
